/* File: logic/dsup_pkg.sv */
`default_nettype none
package dsup_pkg;

  // ****************************************************************
  // Packet and frame layout.
  // ****************************************************************
  localparam int HDR_BYTES = 32;
  localparam int MAX_DATA = 1400;
  localparam int MAX_PKT = 1432;
  localparam int LEN_W = 11;
  localparam int OFS_VERSION = 0;
  localparam int OFS_SEQ = 2;
  localparam int OFS_FRAG = 4;
  localparam int OFS_LEN = 6;
  localparam int OFS_TOTAL = 8;
  localparam int OFS_CRC = 12;
  localparam int OFS_FLAGS = 16;
  localparam int OFS_RSVD = 20;
  localparam int OFS_DATA = 32;
  localparam int FH_LEAD = 4;
  localparam int FH_BYTES = 64;
  localparam logic [15:0] PROTO_VERSION = 16'h0001;
  localparam logic [15:0] FH_RESERVED = 16'hFFFF;
  localparam logic [15:0] FH_REVISION = 16'h0003;
  localparam int FLAG_SKIP_CHECK_BIT = 0;

  // ****************************************************************
  // Checksum and destination defaults.
  // ****************************************************************
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'h0FFF_FFFF;
  localparam logic [31:0] DEF_DEST_IP = 32'hE000_0001;
  localparam logic [15:0] DEF_DEST_PORT = 16'h2712;

  typedef struct packed {
    logic [15:0] version;
    logic [15:0] seq;
    logic [15:0] frag;
    logic [15:0] len;
    logic [31:0] total;
    logic [31:0] crc;
    logic [31:0] flags;
    logic [95:0] rsvd;
  } dsup_hdr_s;

  typedef struct packed {
    logic [31:0] ip;
    logic [15:0] port;
  } dsup_dest_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HCRC = 4'b0010,
    ST_FILL = 4'b0100,
    ST_SEND = 4'b1000
  } dsup_state_e;

endpackage
`default_nettype wire

/* File: logic/dsup_crc32.sv */
`default_nettype none
module dsup_crc32 (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);

  // ****************************************************************
  // Bytewise update, most significant bit first, no final inversion.
  // ****************************************************************
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;

  always_comb begin
    logic fb;
    fb = 1'b0;
    nxt_crc = crc_ff;
    for (int i = 0; i < 8; i++) begin
      fb = nxt_crc[31] ^ data[7-i];
      nxt_crc = {nxt_crc[30:0], 1'b0};
      if (fb) begin
        nxt_crc = nxt_crc ^ dsup_pkg::CRC_POLY;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      crc_ff <= dsup_pkg::CRC_INIT;
    end else if (ce) begin
      if (clr) begin
        crc_ff <= dsup_pkg::CRC_INIT;
      end else if (en) begin
        crc_ff <= nxt_crc;
      end
    end
  end

  assign crc = crc_ff;

endmodule
`default_nettype wire

/* File: logic/dsup_packetizer.sv */
`default_nettype none
module dsup_packetizer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic stream_en_wr,
  input wire logic stream_en_val,
  input wire logic net_cfg_wr,
  input wire dsup_pkg::dsup_dest_s net_cfg_dest,
  input wire logic skip_check_flag,
  output dsup_pkg::dsup_dest_s stream_network_settings,
  output logic stream_active,
  input wire logic frame_start,
  input wire logic [31:0] image_total_size,
  output logic frame_busy,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready,
  output logic [15:0] frame_sequence_count,
  output logic [15:0] fragment_index
);

  // ****************************************************************
  // State and registers.
  // ****************************************************************
  dsup_pkg::dsup_state_e st_ff;
  dsup_pkg::dsup_state_e nxt_st;
  logic en_ff;
  dsup_pkg::dsup_dest_s dest_ff;
  logic [10:0] idx_ff;
  logic [10:0] nxt_idx;
  logic [10:0] len_ff;
  logic [31:0] remain_ff;
  logic [31:0] total_ff;
  logic [31:0] pos_ff;
  logic [15:0] seq_ff;
  logic [15:0] frag_ff;
  logic flag_ff;
  logic out_valid_ff;
  logic [7:0] out_data_ff;
  logic out_last_ff;
  logic [7:0] data_mem [dsup_pkg::MAX_DATA];

  function automatic logic [10:0] clip_len(input logic [31:0] r);
    clip_len = (r < 32'(dsup_pkg::MAX_DATA)) ? r[10:0] : 11'(dsup_pkg::MAX_DATA);
  endfunction

  // ****************************************************************
  // Decode.
  // ****************************************************************
  wire st_idle = (st_ff == dsup_pkg::ST_IDLE);
  wire st_hcrc = (st_ff == dsup_pkg::ST_HCRC);
  wire st_fill = (st_ff == dsup_pkg::ST_FILL);
  wire st_send = (st_ff == dsup_pkg::ST_SEND);
  wire start_ok = st_idle && frame_start && en_ff && (image_total_size != 32'h0000_0000);
  wire lead = pos_ff < 32'(dsup_pkg::FH_LEAD);
  wire [31:0] lead_word = {dsup_pkg::FH_RESERVED, dsup_pkg::FH_REVISION};
  wire [4:0] lead_base = 5'(5'd31 - {pos_ff[1:0], 3'b000});
  wire [7:0] lead_byte = lead_word[lead_base -: 8];
  wire fill_take = st_fill && (lead || in_valid);
  // The frame header's fixed opening is made here; the source supplies the rest of it.
  wire [7:0] fill_data = lead ? lead_byte : in_data;
  wire fill_last = idx_ff == 11'(len_ff - 11'd1);
  wire slot_free = !out_valid_ff || out_ready;
  wire send_step = st_send && slot_free;
  wire last_byte = idx_ff == 11'(len_ff + 11'(dsup_pkg::HDR_BYTES - 1));
  wire pkt_end = send_step && last_byte;
  wire [31:0] rem_after = remain_ff - {21'h0, len_ff};
  wire frame_done = pkt_end && (rem_after == 32'h0000_0000);
  wire pkt_start = start_ok || (pkt_end && !frame_done);
  wire [31:0] crc_q;
  wire [31:0] crc_field = st_send ? crc_q : 32'h0000_0000;

  // The checksum field reads as zero while it is being summed, then carries the result.
  dsup_pkg::dsup_hdr_s hdr_w;
  assign hdr_w.version = dsup_pkg::PROTO_VERSION;
  assign hdr_w.seq = seq_ff;
  assign hdr_w.frag = frag_ff;
  assign hdr_w.len = {5'h00, len_ff};
  assign hdr_w.total = total_ff;
  assign hdr_w.crc = crc_field;
  assign hdr_w.flags = {31'h0000_0000, flag_ff};
  assign hdr_w.rsvd = '0;
  wire [255:0] hdr_vec = hdr_w;
  wire [7:0] hdr_base = 8'(8'd255 - {idx_ff[4:0], 3'b000});
  wire [7:0] hdr_byte = hdr_vec[hdr_base -: 8];
  wire [10:0] mem_rd = 11'(idx_ff - 11'(dsup_pkg::OFS_DATA));
  wire in_hdr = idx_ff < 11'(dsup_pkg::HDR_BYTES);
  wire [7:0] send_byte = in_hdr ? hdr_byte : data_mem[mem_rd];
  wire crc_en = st_hcrc || fill_take;
  wire [7:0] crc_byte = st_hcrc ? hdr_byte : fill_data;

  // Header first, then data: the same order in which bytes go out, so the sum is whole.
  dsup_crc32 u_crc (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clr(pkt_start),
    .en(crc_en),
    .data(crc_byte),
    .crc(crc_q)
  );

  // ****************************************************************
  // Sequencing.
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    case (st_ff)
      dsup_pkg::ST_IDLE: begin
        nxt_idx = 11'h000;
        if (start_ok) begin
          nxt_st = dsup_pkg::ST_HCRC;
        end
      end
      dsup_pkg::ST_HCRC: begin
        nxt_idx = 11'(idx_ff + 11'd1);
        if (idx_ff == 11'(dsup_pkg::HDR_BYTES - 1)) begin
          nxt_idx = 11'h000;
          nxt_st = dsup_pkg::ST_FILL;
        end
      end
      dsup_pkg::ST_FILL: begin
        if (fill_take) begin
          nxt_idx = fill_last ? 11'h000 : 11'(idx_ff + 11'd1);
          if (fill_last) begin
            nxt_st = dsup_pkg::ST_SEND;
          end
        end
      end
      dsup_pkg::ST_SEND: begin
        if (send_step) begin
          nxt_idx = last_byte ? 11'h000 : 11'(idx_ff + 11'd1);
        end
        if (pkt_end) begin
          nxt_st = frame_done ? dsup_pkg::ST_IDLE : dsup_pkg::ST_HCRC;
        end
      end
      default: begin
        nxt_st = dsup_pkg::ST_IDLE;
        nxt_idx = 11'h000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= dsup_pkg::ST_IDLE;
      idx_ff <= 11'h000;
    end else if (ce) begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
    end
  end

  // Disabling the stream only blocks the next frame; a frame under way is finished.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_ff <= 1'b1;
      dest_ff <= '{ip: dsup_pkg::DEF_DEST_IP, port: dsup_pkg::DEF_DEST_PORT};
    end else if (ce) begin
      if (stream_en_wr) begin
        en_ff <= stream_en_val;
      end
      if (net_cfg_wr) begin
        dest_ff <= net_cfg_dest;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      len_ff <= 11'h000;
      remain_ff <= 32'h0000_0000;
      total_ff <= 32'h0000_0000;
      flag_ff <= 1'b0;
    end else if (ce) begin
      if (start_ok) begin
        total_ff <= image_total_size;
        remain_ff <= image_total_size;
        len_ff <= clip_len(image_total_size);
      end else if (pkt_end) begin
        remain_ff <= rem_after;
        len_ff <= clip_len(rem_after);
      end
      if (pkt_start) begin
        flag_ff <= skip_check_flag;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq_ff <= 16'h0000;
      frag_ff <= 16'h0000;
      pos_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (start_ok) begin
        frag_ff <= 16'h0000;
        pos_ff <= 32'h0000_0000;
      end else if (pkt_end) begin
        frag_ff <= 16'(frag_ff + 16'd1);
      end
      if (frame_done) begin
        seq_ff <= 16'(seq_ff + 16'd1);
      end
      if (fill_take) begin
        pos_ff <= 32'(pos_ff + 32'd1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce && fill_take) begin
      data_mem[idx_ff] <= fill_data;
    end
  end

  // A one-byte output slot keeps data on flip-flops while ready may stall it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
      out_last_ff <= 1'b0;
    end else if (ce) begin
      if (send_step) begin
        out_valid_ff <= 1'b1;
        out_data_ff <= send_byte;
        out_last_ff <= last_byte;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  assign in_ready = ce && st_fill && !lead;
  assign out_valid = out_valid_ff && ce;
  assign out_data = out_data_ff;
  assign out_last = out_last_ff;
  assign frame_busy = !st_idle;
  assign stream_active = en_ff;
  assign stream_network_settings = dest_ff;
  assign frame_sequence_count = seq_ff;
  assign fragment_index = frag_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [10:0] out_cnt_ff;
  wire hs = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_cnt_ff <= 11'h000;
    end else if (hs) begin
      out_cnt_ff <= out_last ? 11'h000 : 11'(out_cnt_ff + 11'd1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_len_max;
    !st_idle |-> (len_ff <= 11'(dsup_pkg::MAX_DATA)) && (len_ff != 11'h000);
  endproperty
  a_len_max: assert property (p_len_max) else $error("payload length out of range");
  property p_pkt_len;
    hs && out_last |-> (out_cnt_ff >= 11'(dsup_pkg::HDR_BYTES))
      && (out_cnt_ff <= 11'(dsup_pkg::MAX_PKT - 1));
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("packet length out of range");
  property p_version;
    hs |-> (out_cnt_ff != 11'(dsup_pkg::OFS_VERSION) || out_data == dsup_pkg::PROTO_VERSION[15:8])
      && (out_cnt_ff != 11'd1 || out_data == dsup_pkg::PROTO_VERSION[7:0]);
  endproperty
  a_version: assert property (p_version) else $error("bad protocol version byte");
  property p_seq_step;
    ce && frame_done |=> seq_ff == 16'($past(seq_ff) + 16'd1);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence count did not advance");
  property p_frag_step;
    ce && pkt_end && !frame_done |=> st_hcrc && frag_ff == 16'($past(frag_ff) + 16'd1);
  endproperty
  a_frag_step: assert property (p_frag_step) else $error("fragment index not consecutive");
  property p_len_field;
    hs && out_cnt_ff == 11'(dsup_pkg::OFS_LEN + 1) |-> out_data == len_ff[7:0];
  endproperty
  a_len_field: assert property (p_len_field) else $error("length field mismatch");
  property p_total_field;
    hs && out_cnt_ff == 11'(dsup_pkg::OFS_TOTAL) |-> out_data == total_ff[31:24];
  endproperty
  a_total_field: assert property (p_total_field) else $error("total size field mismatch");
  property p_crc_field;
    hs && out_cnt_ff == 11'(dsup_pkg::OFS_CRC) |-> st_send && out_data == crc_q[31:24];
  endproperty
  a_crc_field: assert property (p_crc_field) else $error("checksum field mismatch");
  property p_flag_field;
    hs && out_cnt_ff == 11'(dsup_pkg::OFS_RSVD - 1) |-> out_data == {7'h00, flag_ff};
  endproperty
  a_flag_field: assert property (p_flag_field) else $error("flags field mismatch");
  property p_rsvd_zero;
    hs && out_cnt_ff >= 11'(dsup_pkg::OFS_RSVD) && out_cnt_ff < 11'(dsup_pkg::OFS_DATA)
      |-> out_data == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved header byte not zero");
  property p_lead_rev;
    fill_take && pos_ff == 32'd3 |-> fill_data == dsup_pkg::FH_REVISION[7:0];
  endproperty
  a_lead_rev: assert property (p_lead_rev) else $error("frame header revision wrong");
  property p_disabled;
    ce && st_idle && !en_ff |=> st_idle;
  endproperty
  a_disabled: assert property (p_disabled) else $error("frame started while disabled");

endmodule
`default_nettype wire

/* File: test/dsup_sink_model.sv */
`default_nettype none
// ****************************************************************
// Receiving host: collects packet bytes in arrival order.
// ****************************************************************
module dsup_sink_model (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pkt_q[$];
  int pkts = 0;
  initial out_ready = 1'b0;
  // Bytes are kept in order so packets can be rebuilt by index.
  always @(posedge sys_clk) begin
    if (out_valid && out_ready) begin
      pkt_q.push_back(out_data);
      if (out_last) pkts++;
    end
    // A slow host takes a byte only every other cycle.
    #2 out_ready <= stall ? ~out_ready : 1'b1;
  end
endmodule
`default_nettype wire

/* File: test/depth_stream_udp_packetizer_bench.sv */
`default_nettype none
module depth_stream_udp_packetizer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic stream_en_wr = 1'b0;
  logic stream_en_val = 1'b1;
  logic net_cfg_wr = 1'b0;
  dsup_pkg::dsup_dest_s net_cfg_dest = '0;
  logic skip_check_flag = 1'b0;
  dsup_pkg::dsup_dest_s stream_network_settings;
  logic stream_active, frame_start = 1'b0, frame_busy;
  logic [31:0] image_total_size = '0;
  logic in_valid = 1'b0, in_ready, out_valid, out_last, out_ready, stall = 1'b0;
  logic [7:0] in_data = '0, out_data;
  logic [15:0] frame_sequence_count, fragment_index;
  int fails = 0, cmp_count = 0, cycles = 0, src_idx = 0, pk = 0;

  dsup_packetizer i_dsup_packetizer (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .stream_en_wr(stream_en_wr), .stream_en_val(stream_en_val), .net_cfg_wr(net_cfg_wr),
    .net_cfg_dest(net_cfg_dest), .skip_check_flag(skip_check_flag),
    .stream_network_settings(stream_network_settings), .stream_active(stream_active),
    .frame_start(frame_start), .image_total_size(image_total_size),
    .frame_busy(frame_busy), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .frame_sequence_count(frame_sequence_count),
    .fragment_index(fragment_index));
  dsup_sink_model i_dsup_sink_model (.sys_clk(sys_clk), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready));

  // ****************************************************************
  // Clock, source of frame bytes and hang guard.
  // ****************************************************************
  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] fb(input int k);
    if (k < 2) return 8'hFF;
    if (k == 2) return 8'h00;
    if (k == 3) return 8'h03;
    return k[7:0] ^ 8'h5A;
  endfunction

  // The block makes the first four frame bytes itself, so the source starts at four.
  always @(posedge sys_clk) begin
    if (in_valid && in_ready) src_idx++;
    #2 in_data <= fb(src_idx + 4);
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      if (c[31] ^ d[i]) c = {c[30:0], 1'b0} ^ dsup_pkg::CRC_POLY;
      else c = {c[30:0], 1'b0};
    end
    return c;
  endfunction

  task automatic chk_pkt(input int frag, input int len, input int ofs, input logic [15:0] seq,
                         input logic [31:0] total, input logic skip);
    logic [7:0] b[$];
    logic [31:0] c;
    c = 32'h0FFF_FFFF;
    while (i_dsup_sink_model.pkts <= pk) @(posedge sys_clk);
    pk++;
    check(i_dsup_sink_model.pkt_q.size(), 32 + len, "packet size");
    while (i_dsup_sink_model.pkt_q.size() > 0) b.push_back(i_dsup_sink_model.pkt_q.pop_front());
    check({b[0], b[1]}, 32'h0000_0001, "version");
    check({b[2], b[3]}, {16'h0000, seq}, "sequence");
    check({b[4], b[5]}, frag, "fragment");
    check({b[6], b[7]}, len, "length");
    check({b[8], b[9], b[10], b[11]}, total, "total size");
    check({b[16], b[17], b[18], b[19]}, {31'h0, skip}, "flags");
    for (int i = 20; i < 32; i++) check(b[i], 32'h0000_0000, "reserved");
    for (int i = 0; i < len; i++) check(b[32 + i], fb(ofs + i), "data");
    foreach (b[i]) c = crc_upd(c, (i >= 12 && i < 16) ? 8'h00 : b[i]);
    check({b[12], b[13], b[14], b[15]}, c, "checksum");
  endtask

  task automatic run_frame(input logic [31:0] total, input logic skip, input logic [15:0] seq);
    int ofs, len, frag;
    ofs = 0;
    frag = 0;
    image_total_size = total;
    skip_check_flag = skip;
    src_idx = 0;
    frame_start = 1'b1;
    in_valid = 1'b1;
    tick(1);
    frame_start = 1'b0;
    check(frame_busy, 1'b1, "frame taken");
    check(fragment_index, 32'h0000_0000, "first fragment");
    check(in_ready, 1'b0, "input held during header sum");
    while (ofs < total) begin
      len = (total - ofs > 1400) ? 1400 : total - ofs;
      chk_pkt(frag, len, ofs, seq, total, skip);
      ofs += len;
      frag++;
    end
    while (frame_busy) @(posedge sys_clk);
    #2 in_valid = 1'b0;
    check(frame_sequence_count, seq + 16'h0001, "sequence step");
    tick(1);
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    tick(2);
    sys_rst = 1'b0;
    check(stream_active, 1'b1, "enabled after reset");
    check(stream_network_settings.ip, 32'hE000_0001, "default group");
    check(stream_network_settings.port, 16'h2712, "default port");
    check(frame_busy, 1'b0, "idle after reset");
    $display("test reset done");
    stall = 1'b1;
    run_frame(32'h0000_05DC, 1'b1, 16'h0000);
    stall = 1'b0;
    run_frame(32'h0000_0578, 1'b0, 16'h0001);
    run_frame(32'h0000_0005, 1'b1, 16'h0002);
    $display("test frames done");
    image_total_size = '0;
    frame_start = 1'b1;
    tick(1);
    frame_start = 1'b0;
    check(frame_busy, 1'b0, "empty frame refused");
    ce = 1'b0;
    image_total_size = 32'h0000_0064;
    stream_en_val = 1'b0;
    stream_en_wr = 1'b1;
    frame_start = 1'b1;
    tick(1);
    frame_start = 1'b0;
    check(stream_active, 1'b1, "enable frozen while ce low");
    check(frame_busy, 1'b0, "no start while ce low");
    ce = 1'b1;
    tick(1);
    stream_en_wr = 1'b0;
    check(stream_active, 1'b0, "disabled");
    image_total_size = 32'h0000_0064;
    frame_start = 1'b1;
    tick(1);
    frame_start = 1'b0;
    check(frame_busy, 1'b0, "disabled refuses frame");
    stream_en_val = 1'b1;
    stream_en_wr = 1'b1;
    tick(1);
    stream_en_wr = 1'b0;
    check(stream_active, 1'b1, "enabled again");
    $display("test enable done");
    net_cfg_dest = {32'hC0A8_0A07, 16'h1F40};
    net_cfg_wr = 1'b1;
    tick(1);
    net_cfg_wr = 1'b0;
    check(stream_network_settings.ip, 32'hC0A8_0A07, "destination group");
    check(stream_network_settings.port, 32'h0000_1F40, "destination port");
    $display("test settings done");
    end_of_test();
  end
endmodule
`default_nettype wire
